//--- hw/ptw_time_counter.sv
// Time counters, frame stamping and periodic waveform generator with an APB slave.
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - Free-running count advances at 120 MHz.
// - 32-bit free count wraps after about 35 s.
// - Every received frame gets a stamp when enabled.
// - Transmit stamp only when host requests capture.
// - Capture input latches free count into register.
// - 64-bit time: 32-bit seconds, 32-bit nanoseconds.
// - Nanoseconds reaching compare clear, seconds increment.
// - Stamp formats: 2s/30ns, 32s/30ns, raw free count.
// - Correction 0..15 lengthens each low period.
// - Start time matched to nanoseconds, one shot.
// - Idle level resets to 0, may become 1.
// - Writing stop returns output to idle level.
// ==========================================================
module ptw_time_counter (
	input wire logic core_clk,
	input wire logic reset,
	// APB slave port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Asynchronous capture strobe pin.
	input wire logic captureStrobeInput,
	// Frame events from the MAC, same clock domain.
	input wire logic rxFrameStart,
	input wire logic txFrameStart,
	input wire logic txCaptureReq,
	// Stamp delivered with each received frame.
	output ptw_pkg::ptw_stamp_t rxStamp,
	output logic rxStampValid,
	output logic txStampValid,
	// Periodic waveform output pin.
	output logic periodicWaveOutput
);
	// ==========================================================
	// Register storage
	// ==========================================================
	logic frameStampEnable_r; // Stamping of frames enabled.
	logic [1:0] stampFormat_r; // Selected stamp layout.
	logic [1:0] timestampEnable_r; // Both bits must be set to run.
	logic waveIdleLevel_r; // Level shown while the wave is idle.
	logic [31:0] secondRolloverCompare_r; // Nanoseconds per second.
	logic [31:0] waveHighPeriod_r; // High time in nanoseconds.
	logic [31:0] waveLowPeriod_r; // Low time in nanoseconds.
	logic [3:0] waveQuantCorrection_r; // Extra nanoseconds per low phase.
	logic [31:0] waveStartTime_r; // Nanosecond value that starts the wave.
	logic [31:0] freerunCaptureValue_r; // Free count caught by the pin.
	ptw_pkg::ptw_stamp_t txStamp_r; // Last transmit stamp.
	logic txStampNew_r; // A transmit stamp was taken since reset.

	// Counter state.
	logic [31:0] freeCount_r; // Free-running count.
	logic [7:0] freePhase_r; // Fractional phase of the free count.
	logic [31:0] seconds_r; // Seconds half of the syntonized time.
	logic [31:0] nanos_r; // Nanoseconds half of the syntonized time.
	ptw_pkg::ptw_wave_t waveState_r; // Waveform generator state.
	logic [31:0] waveElapsed_r; // Nanoseconds spent in the current phase.

	// Capture pin synchroniser and edge memory.
	logic capMeta_r;
	logic capSync_r;
	logic capPrev_r;

	// Bus decode, counter, waveform and stamp helpers.
	logic accessDone;
	logic writeDone;
	logic countersRun;
	logic [31:0] nanosNxt;
	logic rollover;
	logic [31:0] phaseLen;
	logic [31:0] elapsedNxt;
	logic phaseEnd;
	logic startHit;
	logic stopReq;
	ptw_pkg::ptw_stamp_t stampNow;

	// A transfer completes at the edge where the registered ready is seen.
	assign accessDone = psel && penable && pready;
	assign writeDone = accessDone && pwrite && !pslverr;
	// Counting needs both enable bits, as software must set them.
	assign countersRun = (timestampEnable_r == 2'h3);
	assign stopReq = writeDone && (paddr == ptw_pkg::OFS_TSCTRL) && pwdata[ptw_pkg::STOP_BIT];

	// ==========================================================
	// APB slave
	// ==========================================================
	// Ready rises one cycle into the access phase and lasts one cycle;
	// read data and the error flag are loaded together with it.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			unique case (paddr)
				ptw_pkg::OFS_CONFIG_REGISTER_ZERO: prdata <= {29'h0, stampFormat_r, frameStampEnable_r};
				ptw_pkg::OFS_TSCTRL: prdata <= {29'h0, waveIdleLevel_r, timestampEnable_r};
				ptw_pkg::OFS_ROLLCMP: prdata <= secondRolloverCompare_r;
				ptw_pkg::OFS_WAVEHI: prdata <= waveHighPeriod_r;
				ptw_pkg::OFS_WAVELO: prdata <= waveLowPeriod_r;
				ptw_pkg::OFS_QCORR: prdata <= {28'h0, waveQuantCorrection_r};
				ptw_pkg::OFS_START: prdata <= waveStartTime_r;
				ptw_pkg::OFS_FREENOW: prdata <= freeCount_r;
				ptw_pkg::OFS_FREECAP: prdata <= freerunCaptureValue_r;
				ptw_pkg::OFS_SEC: prdata <= seconds_r;
				ptw_pkg::OFS_NSEC: prdata <= nanos_r;
				ptw_pkg::OFS_TXLO: prdata <= txStamp_r.lo;
				ptw_pkg::OFS_TXHI: prdata <= txStamp_r.hi;
				ptw_pkg::OFS_STATUS: prdata <= {29'h0, txStampNew_r,
					waveState_r == ptw_pkg::PTW_WAVE_ARMED,
					waveState_r == ptw_pkg::PTW_WAVE_HIGH || waveState_r == ptw_pkg::PTW_WAVE_LOW};
				// Unmapped offsets answer with an error and zero data.
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Software-written configuration; read-only offsets ignore writes.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			frameStampEnable_r <= 1'b0;
			stampFormat_r <= 2'h0;
			timestampEnable_r <= 2'h0;
			waveIdleLevel_r <= 1'b0;
			secondRolloverCompare_r <= ptw_pkg::ROLL_RESET;
			waveHighPeriod_r <= 32'h0;
			waveLowPeriod_r <= 32'h0;
			waveQuantCorrection_r <= 4'h0;
			waveStartTime_r <= 32'h0;
		end else if (writeDone) begin
			unique case (paddr)
				ptw_pkg::OFS_CONFIG_REGISTER_ZERO: begin
					frameStampEnable_r <= pwdata[ptw_pkg::FSE_BIT];
					stampFormat_r <= pwdata[ptw_pkg::FMT_LSB +: 2];
				end
				ptw_pkg::OFS_TSCTRL: begin
					timestampEnable_r <= pwdata[ptw_pkg::TSEN_LSB +: 2];
					waveIdleLevel_r <= pwdata[ptw_pkg::IDLE_BIT];
				end
				ptw_pkg::OFS_ROLLCMP: secondRolloverCompare_r <= pwdata;
				ptw_pkg::OFS_WAVEHI: waveHighPeriod_r <= pwdata;
				ptw_pkg::OFS_WAVELO: waveLowPeriod_r <= pwdata;
				ptw_pkg::OFS_QCORR: waveQuantCorrection_r <= pwdata[3:0];
				ptw_pkg::OFS_START: waveStartTime_r <= pwdata;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Free-running counter
	// ==========================================================
	// A phase accumulator steps 120 of every 200 units per core cycle, so
	// the count advances on average at 120 MHz; single counts jitter by one
	// core cycle, which is the price of staying on one clock.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			freePhase_r <= 8'h0;
			freeCount_r <= 32'h0;
		end else if (countersRun) begin
			if ({1'b0, freePhase_r} + {1'b0, ptw_pkg::FREE_INC} >= {1'b0, ptw_pkg::FREE_MOD}) begin
				freePhase_r <= 8'(freePhase_r + ptw_pkg::FREE_INC - ptw_pkg::FREE_MOD);
				// Full 32 bits: wraps after about 35.8 s.
				freeCount_r <= freeCount_r + 32'h1;
			end else begin
				freePhase_r <= 8'(freePhase_r + ptw_pkg::FREE_INC);
			end
		end
	end

	// Two flops bring the pin into the core domain; a third remembers the
	// previous level so that only the rising edge captures.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			capMeta_r <= 1'b0;
			capSync_r <= 1'b0;
			capPrev_r <= 1'b0;
		end else begin
			capMeta_r <= captureStrobeInput;
			capSync_r <= capMeta_r;
			capPrev_r <= capSync_r;
		end
	end

	// The capture register holds the count seen at the strobe edge.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			freerunCaptureValue_r <= 32'h0;
		end else if (capSync_r && !capPrev_r) begin
			freerunCaptureValue_r <= freeCount_r;
		end
	end

	// ==========================================================
	// Syntonized counter
	// ==========================================================
	// The nanoseconds half advances 5 ns per cycle; reaching the compare
	// value clears it (keeping any overshoot) and bumps the seconds.
	assign nanosNxt = nanos_r + ptw_pkg::NS_STEP;
	assign rollover = (nanosNxt >= secondRolloverCompare_r);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			seconds_r <= 32'h0;
			nanos_r <= 32'h0;
		end else if (countersRun) begin
			if (rollover) begin
				nanos_r <= nanosNxt - secondRolloverCompare_r;
				seconds_r <= seconds_r + 32'h1;
			end else begin
				nanos_r <= nanosNxt;
			end
		end
	end

	// ==========================================================
	// Frame time stamps
	// ==========================================================
	// Stamp layout chosen by the format field.
	always_comb begin
		stampNow = '0;
		unique case (stampFormat_r)
			ptw_pkg::PTW_FMT_SHORT: stampNow.lo = {seconds_r[1:0], nanos_r[29:0]};
			ptw_pkg::PTW_FMT_LONG: stampNow = {seconds_r, 2'h0, nanos_r[29:0]};
			default: stampNow.lo = freeCount_r;
		endcase
	end

	// Every received frame start is stamped while stamping is on and the counters run; the MAC
	// places the stamp ahead of the frame data.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rxStamp <= '0;
			rxStampValid <= 1'b0;
		end else begin
			rxStampValid <= rxFrameStart && frameStampEnable_r && countersRun;
			if (rxFrameStart && frameStampEnable_r && countersRun) begin
				rxStamp <= stampNow;
			end
		end
	end

	// Transmit frames are stamped only on request.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			txStamp_r <= '0;
			txStampNew_r <= 1'b0;
			txStampValid <= 1'b0;
		end else begin
			txStampValid <= txFrameStart && txCaptureReq && frameStampEnable_r && countersRun;
			if (txFrameStart && txCaptureReq && frameStampEnable_r && countersRun) begin
				txStamp_r <= stampNow;
				txStampNew_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Waveform generator
	// ==========================================================
	// The low phase carries the quantization correction so that a period
	// that is not a multiple of sixteen averages out right. Periods that are
	// not multiples of sixteen still work here, but software keeps to them.
	assign phaseLen = (waveState_r == ptw_pkg::PTW_WAVE_HIGH) ? waveHighPeriod_r :
		waveLowPeriod_r + {28'h0, waveQuantCorrection_r};
	assign elapsedNxt = waveElapsed_r + ptw_pkg::NS_STEP;
	assign phaseEnd = (elapsedNxt >= phaseLen);
	// The start value matches when it falls inside this cycle's 5 ns step.
	assign startHit = countersRun && ((waveStartTime_r - nanos_r) < ptw_pkg::NS_STEP);

	// Writing the start time arms one start; stop always wins.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			waveState_r <= ptw_pkg::PTW_WAVE_IDLE;
			waveElapsed_r <= 32'h0;
		end else if (stopReq) begin
			waveState_r <= ptw_pkg::PTW_WAVE_IDLE;
			waveElapsed_r <= 32'h0;
		end else if (writeDone && paddr == ptw_pkg::OFS_START) begin
			waveState_r <= ptw_pkg::PTW_WAVE_ARMED;
			waveElapsed_r <= 32'h0;
		end else begin
			unique case (waveState_r)
				ptw_pkg::PTW_WAVE_IDLE: ;
				ptw_pkg::PTW_WAVE_ARMED: begin
					if (startHit) begin
						waveState_r <= ptw_pkg::PTW_WAVE_HIGH;
					end
				end
				ptw_pkg::PTW_WAVE_HIGH, ptw_pkg::PTW_WAVE_LOW: begin
					// Time only moves while the syntonized counter runs.
					if (countersRun) begin
						if (phaseEnd) begin
							// Overshoot carries into the next phase.
							waveElapsed_r <= elapsedNxt - phaseLen;
							waveState_r <= (waveState_r == ptw_pkg::PTW_WAVE_HIGH) ?
								ptw_pkg::PTW_WAVE_LOW : ptw_pkg::PTW_WAVE_HIGH;
						end else begin
							waveElapsed_r <= elapsedNxt;
						end
					end
				end
			endcase
		end
	end

	// Output pin follows the phase, or the idle level when not running.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			periodicWaveOutput <= 1'b0;
		end else if (stopReq) begin
			periodicWaveOutput <= pwdata[ptw_pkg::IDLE_BIT];
		end else begin
			unique case (waveState_r)
				ptw_pkg::PTW_WAVE_HIGH: periodicWaveOutput <= 1'b1;
				ptw_pkg::PTW_WAVE_LOW: periodicWaveOutput <= 1'b0;
				default: periodicWaveOutput <= waveIdleLevel_r;
			endcase
		end
	end
endmodule

//--- include/ptw_pkg.sv
// Package with register map, field positions, reset values and timing constants.
package ptw_pkg;
	// ==========================================================
	// Clock and counter timing
	// ==========================================================
	// Core clock rate in MHz; one core cycle is 5 ns.
	localparam int unsigned CORE_MHZ = 200;
	// Free-running counter rate in MHz.
	localparam int unsigned FREE_MHZ = 120;
	// Nanoseconds added to the syntonized time on each core cycle.
	localparam logic [31:0] NS_STEP = 32'(1000 / CORE_MHZ);
	// Phase accumulator modulus and increment for the 120 MHz count.
	localparam logic [7:0] FREE_MOD = 8'(CORE_MHZ);
	localparam logic [7:0] FREE_INC = 8'(FREE_MHZ);
	// Nanoseconds in one second, the rollover compare reset value.
	localparam logic [31:0] ROLL_RESET = 32'h3b9aca00;

	// ==========================================================
	// Register byte offsets
	// ==========================================================
	localparam logic [7:0] OFS_CONFIG_REGISTER_ZERO = 8'h00;
	localparam logic [7:0] OFS_TSCTRL = 8'h04;
	localparam logic [7:0] OFS_ROLLCMP = 8'h08;
	localparam logic [7:0] OFS_WAVEHI = 8'h0c;
	localparam logic [7:0] OFS_WAVELO = 8'h10;
	localparam logic [7:0] OFS_QCORR = 8'h14;
	localparam logic [7:0] OFS_START = 8'h18;
	localparam logic [7:0] OFS_FREENOW = 8'h1c;
	localparam logic [7:0] OFS_FREECAP = 8'h20;
	localparam logic [7:0] OFS_SEC = 8'h24;
	localparam logic [7:0] OFS_NSEC = 8'h28;
	localparam logic [7:0] OFS_TXLO = 8'h2c;
	localparam logic [7:0] OFS_TXHI = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;

	// ==========================================================
	// Field positions
	// ==========================================================
	// Config register zero: frame stamp enable and stamp format.
	localparam int FSE_BIT = 0;
	localparam int FMT_LSB = 1;
	// Timestamp control: two enable bits, idle level, stop bit.
	localparam int TSEN_LSB = 0;
	localparam int IDLE_BIT = 2;
	localparam int STOP_BIT = 3;
	// Status: wave running, start armed, tx stamp taken.
	localparam int ST_RUN_BIT = 0;
	localparam int ST_ARM_BIT = 1;
	localparam int ST_TX_BIT = 2;

	// Frame stamp formats.
	typedef enum logic [1:0] {
		PTW_FMT_SHORT = 2'h0,
		PTW_FMT_LONG = 2'h1,
		PTW_FMT_FREE = 2'h2
	} ptw_fmt_t;

	// Waveform generator states, Gray coded along the cycle.
	typedef enum logic [1:0] {
		PTW_WAVE_IDLE = 2'h0,
		PTW_WAVE_ARMED = 2'h1,
		PTW_WAVE_HIGH = 2'h3,
		PTW_WAVE_LOW = 2'h2
	} ptw_wave_t;

	// A 64-bit stamp as delivered with a frame.
	typedef struct packed {
		logic [31:0] hi;
		logic [31:0] lo;
	} ptw_stamp_t;
endpackage

//--- testbench/ptw_time_counter_checker.sv
// Concurrent checks on the ports of the time counter block.
`timescale 1ns/1ps
module ptw_time_counter_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxFrameStart,
	input wire logic txFrameStart,
	input wire logic txCaptureReq,
	input wire logic rxStampValid,
	input wire logic txStampValid,
	input wire logic periodicWaveOutput
);
	// ==========================================================
	// Shadow of the enables, rebuilt from completed writes.
	// ==========================================================
	logic wrDone;
	logic fseOn_r;
	logic [1:0] tsEn_r;
	assign wrDone = psel && penable && pready && pwrite;
	// Only the edge that completes a write may change the shadow.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fseOn_r <= 1'b0;
			tsEn_r <= 2'h0;
		end else if (wrDone && paddr == ptw_pkg::OFS_CONFIG_REGISTER_ZERO) begin
			fseOn_r <= pwdata[ptw_pkg::FSE_BIT];
		end else if (wrDone && paddr == ptw_pkg::OFS_TSCTRL) begin
			tsEn_r <= pwdata[1:0];
		end
	end
	// ==========================================================
	// Assertions.
	// ==========================================================
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_unmapped_err: assert property (pready |->
		pslverr == (paddr > ptw_pkg::OFS_STATUS || paddr[1:0] != 2'h0))
		else $error("error response does not match the address");
	a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("error response carries data");
	a_rx_after_start: assert property (rxStampValid |-> $past(rxFrameStart && fseOn_r && tsEn_r == 2'h3))
		else $error("receive stamp without an enabled frame start");
	a_rx_when_enabled: assert property (rxFrameStart && fseOn_r && tsEn_r == 2'h3 |=> rxStampValid)
		else $error("receive frame missed its stamp");
	a_tx_needs_req: assert property (txStampValid |-> $past(txFrameStart && txCaptureReq))
		else $error("transmit stamp without a request");
	a_stop_idle: assert property (wrDone && paddr == ptw_pkg::OFS_TSCTRL && pwdata[ptw_pkg::STOP_BIT] |=> periodicWaveOutput == $past(pwdata[ptw_pkg::IDLE_BIT]))
		else $error("stopped waveform not at idle level");
	c_start_write: cover property (wrDone && paddr == ptw_pkg::OFS_START);
	c_rx_stamp: cover property (rxStampValid);
	c_err_resp: cover property (pready && pslverr);
endmodule
bind ptw_time_counter ptw_time_counter_checker i_chk (.core_clk(core_clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxFrameStart(rxFrameStart),
	.txFrameStart(txFrameStart), .txCaptureReq(txCaptureReq), .rxStampValid(rxStampValid),
	.txStampValid(txStampValid), .periodicWaveOutput(periodicWaveOutput));

//--- testbench/ptw_time_counter_tb.sv
// Self-checking testbench for the time counter and waveform block.
`timescale 1ns/1ps
module ptw_time_counter_tb;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, errV, vld;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdV;
	logic captureStrobeInput, rxFrameStart, txFrameStart, txCaptureReq;
	logic rxStampValid, txStampValid, periodicWaveOutput;
	ptw_pkg::ptw_stamp_t rxStamp;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int cycAt;
	ptw_time_counter i_dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .captureStrobeInput(captureStrobeInput), .rxFrameStart(rxFrameStart),
		.txFrameStart(txFrameStart), .txCaptureReq(txCaptureReq), .rxStamp(rxStamp),
		.rxStampValid(rxStampValid), .txStampValid(txStampValid),
		.periodicWaveOutput(periodicWaveOutput));
	// ==========================================================
	// Clock, cycle count and shared tasks.
	// ==========================================================
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// A wait that ran out counts as a mismatch and ends the run.
	task automatic hang();
		bad_count++;
		final_report();
	endtask
	task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; it leaves one idle cycle so no signal is set twice in a step.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) hang();
		rdV = prdata;
		errV = pslverr;
		cycAt = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check_word({errV, rdV}, {1'b0, exp});
	endtask
	// Pulses one frame start and samples the stamp flag mid-cycle while it stands.
	task automatic frame(input logic rx, input logic req);
		rxFrameStart <= rx;
		txFrameStart <= !rx;
		txCaptureReq <= req;
		@(posedge core_clk);
		rxFrameStart <= 1'b0;
		txFrameStart <= 1'b0;
		txCaptureReq <= 1'b0;
		@(negedge core_clk);
		vld = rx ? rxStampValid : txStampValid;
		@(posedge core_clk);
	endtask
	// Length of a run of the waveform at one level, sampled mid-cycle.
	task automatic run_len(input logic lvl, output int n);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (periodicWaveOutput === lvl && n < 300);
		if (n >= 300) hang();
	endtask
	// ==========================================================
	// Scenarios.
	// ==========================================================
	task automatic reset_state();
		rd_chk(ptw_pkg::OFS_ROLLCMP, ptw_pkg::ROLL_RESET);
		repeat (20) @(posedge core_clk);
		rd_chk(ptw_pkg::OFS_NSEC, 32'h0);
		rd_chk(ptw_pkg::OFS_FREENOW, 32'h0);
		check_word(periodicWaveOutput, 64'h0);
		apb(1'b0, 8'h40, 32'h0);
		check_word({errV, rdV}, {1'b1, 32'h0});
		apb(1'b1, ptw_pkg::OFS_FREECAP, 32'h1234);
		rd_chk(ptw_pkg::OFS_FREECAP, 32'h0);
	endtask
	// Runs the counters for a measured span, then freezes and reads them.
	task automatic counters();
		int d, s, ns, f, t;
		apb(1'b1, ptw_pkg::OFS_ROLLCMP, 32'd100);
		apb(1'b1, ptw_pkg::OFS_TSCTRL, 32'h3);
		d = cycAt;
		repeat (200) @(posedge core_clk);
		apb(1'b1, ptw_pkg::OFS_TSCTRL, 32'h0);
		d = cycAt - d;
		apb(1'b0, ptw_pkg::OFS_SEC, 32'h0);
		s = rdV;
		apb(1'b0, ptw_pkg::OFS_NSEC, 32'h0);
		ns = rdV;
		apb(1'b0, ptw_pkg::OFS_FREENOW, 32'h0);
		f = rdV;
		t = s * 100 + ns;
		check_word(ns < 100 && ns % 5 == 0, 64'h1);
		check_word(t >= 5 * (d - 2) && t <= 5 * (d + 2), 64'h1);
		check_word(f >= (d - 2) * 3 / 5 - 1 && f <= (d + 2) * 3 / 5 + 1, 64'h1);
		captureStrobeInput <= 1'b1;
		repeat (4) @(posedge core_clk);
		captureStrobeInput <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd_chk(ptw_pkg::OFS_FREECAP, 32'(f));
	endtask
	// Every stamp format, a disabled stamp and both transmit cases.
	task automatic stamps();
		apb(1'b1, ptw_pkg::OFS_TSCTRL, 32'h3);
		for (int fm = 0; fm < 3; fm++) begin
			apb(1'b1, ptw_pkg::OFS_CONFIG_REGISTER_ZERO, 32'(fm * 2 + 1));
			frame(1'b1, 1'b0);
			check_word(vld, 64'h1);
			check_word(rxStamp.hi == 32'h0 || fm == 1, 64'h1);
			check_word(fm == 2 || (rxStamp.lo[29:0] < 100 && rxStamp.lo[29:0] % 5 == 0), 64'h1);
			check_word(fm != 1 || rxStamp.lo[31:30] == 2'h0, 64'h1);
		end
		apb(1'b1, ptw_pkg::OFS_CONFIG_REGISTER_ZERO, 32'h0);
		frame(1'b1, 1'b0);
		check_word(vld, 64'h0);
		apb(1'b1, ptw_pkg::OFS_CONFIG_REGISTER_ZERO, 32'h1);
		frame(1'b0, 1'b0);
		check_word(vld, 64'h0);
		frame(1'b0, 1'b1);
		check_word(vld, 64'h1);
	endtask
	// Idle high, start in the future, measure one low and one high run, stop.
	task automatic wave();
		int w, lo, hi;
		apb(1'b1, ptw_pkg::OFS_TSCTRL, 32'h7);
		apb(1'b1, ptw_pkg::OFS_ROLLCMP, ptw_pkg::ROLL_RESET);
		check_word(periodicWaveOutput, 64'h1);
		apb(1'b1, ptw_pkg::OFS_WAVEHI, 32'd80);
		apb(1'b1, ptw_pkg::OFS_WAVELO, 32'd160);
		apb(1'b1, ptw_pkg::OFS_QCORR, 32'd15);
		apb(1'b0, ptw_pkg::OFS_NSEC, 32'h0);
		apb(1'b1, ptw_pkg::OFS_START, rdV + 32'd400);
		run_len(1'b1, w);
		check_word(w > 40, 64'h1);
		run_len(1'b0, lo);
		check_word(lo, 64'd35);
		run_len(1'b1, hi);
		check_word(hi, 64'd16);
		@(posedge core_clk);
		apb(1'b1, ptw_pkg::OFS_TSCTRL, 32'hb);
		repeat (20) @(posedge core_clk);
		check_word(periodicWaveOutput, 64'h0);
		rd_chk(ptw_pkg::OFS_STATUS, 32'h4);
	endtask
	// ==========================================================
	// Main sequence.
	// ==========================================================
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{captureStrobeInput, rxFrameStart, txFrameStart, txCaptureReq} = 4'h0;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		reset_state();
		counters();
		stamps();
		wave();
		final_report();
	end
endmodule
